// ---- smm_flash.sv ----
`timescale 1ns/100ps
module smm_flash
  import smm_pkg::*;
#(
  parameter int HALF_CYC = FLASH_HALF_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // link to the manager
  smm_if.src led
);
  logic [31:0] cnt_reg, cnt_next;
  logic phase_reg, phase_next;
  logic wrap;

  assign wrap = (cnt_reg == 32'(HALF_CYC - 1));

  always_comb begin
    cnt_next = wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
    phase_next = wrap ? ~phase_reg : phase_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_reg <= 32'h0000_0000;
      phase_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign led.tick = wrap;
  // steady in safety, blinking in maintenance
  assign led.led_safety = led.maint ? phase_reg : 1'b1;
endmodule

// ---- smm_host_model.sv ----
`timescale 1ns/100ps
module smm_host_model (
  // clock
  input wire logic core_clk,
  // register port towards the manager
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // commands leave by the command word, one strobe each
  // released lines show inverted values so a stale bus never reads right
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ---- smm_if.sv ----
`timescale 1ns/100ps
interface smm_if;
  logic tick;
  logic maint;
  logic led_safety;
  modport src (output tick, input maint, output led_safety);
  modport dst (input tick, output maint, input led_safety);
endinterface

// ---- smm_manager.sv ----
`timescale 1ns/100ps
// How it works
// - configured authorization bit must be one
// - authorization input in error counts as one
// - forcing kept until next maintenance entry
// - host command returns to safety mode
// - fifty seconds without host returns safety
// - debug, breakpoint, watchpoint block safety switch except on standby takeover
// - host command enters maintenance when allowed
// - log every safety entry and exit
// - led flashes maintenance, steady in safety
// - maintenance words A501 and 501A
// - safety puts 5AFE in status words
// - self-test holds while extender unterminated
// - invalid application means no-configuration state
// - valid application powers up in safety
// - disconnect command returns to safety mode
// - dual execution kept, compare off in maintenance
// - standby takeover forces safety mode
module smm_manager
  import smm_pkg::*;
#(
  parameter longint LOSS_CYC = LINK_LOSS_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // plant inputs
  input wire logic maintenance_authorization_input,
  input wire logic auth_input_error,
  input wire logic standby_takeover,
  // outputs
  output logic safety_mode_led,
  output logic copro_safety_mode_led,
  output logic dual_exec_compare_en,
  output logic forcing_active,
  output logic log_event,
  output logic irq
);
  smm_if led_if ();

  smm_flash #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .core_clk(core_clk),
    .resetn(resetn),
    .led(led_if.src)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  smm_state_t state_reg, state_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] log_cnt_reg, log_cnt_next;
  logic [63:0] loss_reg, loss_next;
  logic force_reg, force_next;
  logic log_reg, log_next;

  logic wr_ctrl, wr_cmd, wr_irq, wr_mask;
  logic cmd_maint, cmd_safe, cmd_disc, cmd_alive;
  logic auth_ok, debug_block, timeout, enter_safe, leave_safe, refused;
  logic [IRQ_W-1:0] ev;

  function automatic logic wr_hit(input logic [3:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  assign wr_ctrl = wr_hit(REG_CTRL);
  assign wr_cmd = wr_hit(REG_CMD);
  assign wr_irq = wr_hit(REG_IRQ_STAT);
  assign wr_mask = wr_hit(REG_IRQ_MASK);
  assign cmd_maint = wr_cmd && reg_wdata[CMD_TO_MAINT];
  assign cmd_safe = wr_cmd && reg_wdata[CMD_TO_SAFE];
  assign cmd_disc = wr_cmd && reg_wdata[CMD_DISCONNECT];
  assign cmd_alive = wr_cmd && reg_wdata[CMD_HOST_ALIVE];

  // ------------------------------------------------------------
  // transition conditions
  // ------------------------------------------------------------
  // the bit is wired from a local input module by configuration
  // the input error flag makes the bit count as set
  assign auth_ok = !ctrl_reg[CTRL_AUTH_EN]
    || maintenance_authorization_input
    || auth_input_error;
  assign debug_block = ctrl_reg[CTRL_DEBUG] || ctrl_reg[CTRL_BREAK]
    || ctrl_reg[CTRL_WATCH];
  // the refusal also covers the automatic return, so the timer
  // can never tear down a live breakpoint session
  assign timeout = (loss_reg >= 64'(LOSS_CYC - 1)) && !debug_block;

  always_comb begin
    state_next = state_reg;
    refused = 1'b0;
    if (!ctrl_reg[CTRL_APP_VALID]) begin
      // an unterminated extender holds self-test even with no program
      if (state_reg != ST_SELF_TEST
        || (ctrl_reg[CTRL_TEST_DONE] && !ctrl_reg[CTRL_EXT_BAD])) begin
        state_next = ST_NO_CONFIG;
      end
    end else begin
      unique case (state_reg)
        ST_SELF_TEST: begin
          if (ctrl_reg[CTRL_TEST_DONE] && !ctrl_reg[CTRL_EXT_BAD]) begin
            state_next = ST_SAFETY;
          end
        end
        ST_NO_CONFIG: begin
          state_next = ST_SAFETY;
        end
        ST_SAFETY: begin
          if (cmd_maint && !standby_takeover) begin
            if (auth_ok && !debug_block) begin
              state_next = ST_MAINT;
            end else begin
              refused = 1'b1;
            end
          end
        end
        ST_MAINT: begin
          if (standby_takeover) begin
            state_next = ST_SAFETY;
          end else if (cmd_safe || cmd_disc) begin
            if (debug_block) begin
              refused = 1'b1;
            end else begin
              state_next = ST_SAFETY;
            end
          end else if (timeout) begin
            state_next = ST_SAFETY;
          end
        end
      endcase
    end
  end

  assign enter_safe = (state_next == ST_SAFETY) && (state_reg != ST_SAFETY);
  assign leave_safe = (state_reg == ST_SAFETY) && (state_next != ST_SAFETY);

  // ------------------------------------------------------------
  // registers, timer, log, interrupts
  // ------------------------------------------------------------
  assign ev = {timeout && (state_reg == ST_MAINT), refused,
    leave_safe, enter_safe};

  always_comb begin
    ctrl_next = wr_ctrl ? reg_wdata[CTRL_W-1:0] : ctrl_reg;
    irq_mask_next = wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_reg;
    // set wins over a write-one clear in the same cycle
    irq_stat_next = (irq_stat_reg
      & ~(wr_irq ? reg_wdata[IRQ_W-1:0] : IRQ_RESET)) | ev;
    if (state_reg != ST_MAINT || cmd_alive) begin
      loss_next = 64'h0;
    end else begin
      loss_next = loss_reg + 64'h1;
    end
    // forcing survives the return to safety until next entry
    if (state_reg == ST_SAFETY && state_next == ST_MAINT) begin
      force_next = ctrl_reg[CTRL_FORCE];
    end else if (state_reg == ST_MAINT) begin
      force_next = ctrl_reg[CTRL_FORCE];
    end else begin
      force_next = force_reg;
    end
    log_next = enter_safe || leave_safe;
    log_cnt_next = log_cnt_reg + {15'h0000, log_next};
    rdata_next = WORD_IDLE;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: rdata_next = {8'h00, ctrl_reg};
        REG_STATUS: rdata_next = {13'h0000, force_reg, state_reg};
        REG_IRQ_STAT: rdata_next = {12'h000, irq_stat_reg};
        REG_IRQ_MASK: rdata_next = {12'h000, irq_mask_reg};
        REG_COPRO_WORD: rdata_next = copro_word(state_reg);
        REG_CTRL_WORD: rdata_next = ctrl_word(state_reg);
        REG_LOG_COUNT: rdata_next = log_cnt_reg;
        default: rdata_next = WORD_IDLE;
      endcase
    end
  end

  function automatic logic [15:0] copro_word(input smm_state_t s);
    if (s == ST_MAINT) return WORD_COPRO_MAINT;
    if (s == ST_SAFETY) return WORD_SAFE;
    return WORD_IDLE;
  endfunction

  function automatic logic [15:0] ctrl_word(input smm_state_t s);
    if (s == ST_MAINT) return WORD_CTRL_MAINT;
    if (s == ST_SAFETY) return WORD_SAFE;
    return WORD_IDLE;
  endfunction

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= ST_SELF_TEST;
      ctrl_reg <= CTRL_RESET;
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
      rdata_reg <= WORD_IDLE;
      log_cnt_reg <= 16'h0000;
      loss_reg <= 64'h0;
      force_reg <= 1'b0;
      log_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
      log_cnt_reg <= log_cnt_next;
      loss_reg <= loss_next;
      force_reg <= force_next;
      log_reg <= log_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign led_if.maint = (state_reg == ST_MAINT);
  assign safety_mode_led = (state_reg == ST_SAFETY || state_reg == ST_MAINT)
    && led_if.led_safety;
  assign copro_safety_mode_led = safety_mode_led;
  // both copies still run; only the comparison is switched off
  assign dual_exec_compare_en = (state_reg != ST_MAINT);
  assign forcing_active = force_reg;
  assign log_event = log_reg;
  assign reg_rdata = rdata_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// ---- smm_manager_bench.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: %h not %h", $time, (a), (e)); end end
module smm_manager_bench;
  import smm_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  // stands for a bit of a local non-interfering input module
  logic auth_in = 1'b0;
  logic auth_err = 1'b0;
  logic takeover = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  logic led;
  logic cled;
  logic cmp_en;
  logic force_on;
  logic irq;
  int bad_count = 0;
  int checks = 0;
  initial forever #25 core_clk = ~core_clk;
  smm_host_model u_host (.core_clk(core_clk), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  // short link-loss count keeps the timeout inside the run
  smm_manager #(.LOSS_CYC(100)) i_dut (.core_clk(core_clk),
    .resetn(resetn), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .maintenance_authorization_input(auth_in),
    .auth_input_error(auth_err), .standby_takeover(takeover),
    .safety_mode_led(led), .copro_safety_mode_led(cled),
    .dual_exec_compare_en(cmp_en), .forcing_active(force_on),
    .log_event(), .irq(irq));
  task automatic rx(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic st(input logic [1:0] e);
    logic [15:0] d;
    u_host.rd(REG_STATUS, d);
    `CHK(d[1:0], e)
  endtask
  task automatic cmd(input int b);
    u_host.wr(REG_CMD, 16'h0001 << b);
  endtask
  task automatic ctl(input logic [7:0] v);
    u_host.wr(REG_CTRL, {8'h00, v});
  endtask
  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rx(REG_COPRO_WORD, WORD_IDLE);
    ctl(8'hE0);
    st(2'b00);
    ctl(8'hC0);
    st(2'b00);
    ctl(8'h40);
    st(2'b01);
    u_host.wr(REG_IRQ_MASK, 16'h000F);
    ctl(8'h60);
    st(2'b10);
    rx(REG_COPRO_WORD, WORD_SAFE);
    rx(REG_CTRL_WORD, WORD_SAFE);
    rx(REG_IRQ_STAT, 16'h0001);
    `CHK(irq, 1'b1)
    u_host.wr(REG_IRQ_STAT, 16'h000F);
    `CHK(irq, 1'b0)
    `CHK({led, cled}, 2'b11)
    ctl(8'h61);
    cmd(CMD_TO_MAINT);
    st(2'b10);
    rx(REG_IRQ_STAT, 16'h0004);
    @(posedge core_clk);
    auth_err <= 1'b1;
    cmd(CMD_TO_MAINT);
    st(2'b11);
    rx(REG_COPRO_WORD, WORD_COPRO_MAINT);
    rx(REG_CTRL_WORD, WORD_CTRL_MAINT);
    `CHK(cmp_en, 1'b0)
    `CHK({led, cled}, 2'b00)
    for (int i = CTRL_DEBUG; i <= CTRL_WATCH; i++) begin
      ctl(8'h71 | (8'h01 << i));
      cmd(CMD_TO_SAFE);
      st(2'b11);
    end
    ctl(8'h71);
    cmd(CMD_TO_SAFE);
    st(2'b10);
    `CHK(force_on, 1'b1)
    @(posedge core_clk);
    auth_err <= 1'b0;
    ctl(8'h60);
    cmd(CMD_TO_MAINT);
    st(2'b11);
    `CHK(force_on, 1'b0)
    cmd(CMD_DISCONNECT);
    st(2'b10);
    rx(REG_LOG_COUNT, 16'h0005);
    u_host.wr(REG_IRQ_STAT, 16'h000F);
    cmd(CMD_TO_MAINT);
    repeat (3) begin
      repeat (60) @(posedge core_clk);
      cmd(CMD_HOST_ALIVE);
    end
    st(2'b11);
    repeat (110) @(posedge core_clk);
    st(2'b10);
    rx(REG_IRQ_STAT, 16'h000B);
    cmd(CMD_TO_MAINT);
    @(posedge core_clk);
    takeover <= 1'b1;
    @(posedge core_clk);
    takeover <= 1'b0;
    st(2'b10);
    u_host.wr(REG_COPRO_WORD, 16'h1234);
    rx(REG_COPRO_WORD, WORD_SAFE);
    rx(4'hF, 16'h0000);
    stop_test;
  end
  // the whole sequence needs about 400 cycles
  initial begin
    #(50 * 40000);
    bad_count++;
    stop_test;
  end
endmodule

// ---- smm_manager_monitor.sv ----
`timescale 1ns/100ps
module smm_manager_monitor
  import smm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // plant side
  input wire logic maintenance_authorization_input,
  input wire logic auth_input_error,
  input wire logic standby_takeover,
  input wire logic safety_mode_led,
  input wire logic copro_safety_mode_led,
  input wire logic dual_exec_compare_en,
  input wire logic forcing_active,
  input wire logic log_event,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // shadow of the control word, seen only through writes
  logic [7:0] ctl_sh;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctl_sh <= 8'h00;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctl_sh <= reg_wdata[7:0];
    end
  end
  wire logic cmd_w = reg_wr && reg_addr == REG_CMD;
  property p_reset;
    disable iff (1'b0) !resetn |=> !log_event && !irq && dual_exec_compare_en;
  endproperty
  a_reset: assert property (p_reset) else $error("reset outputs off");
  property p_led_pair;
    safety_mode_led == copro_safety_mode_led;
  endproperty
  a_led_pair: assert property (p_led_pair) else $error("leds differ");
  property p_log_in;
    $fell(dual_exec_compare_en) |-> ##[0:2] log_event;
  endproperty
  a_log_in: assert property (p_log_in) else $error("exit not logged");
  property p_log_out;
    $rose(dual_exec_compare_en) |-> ##[0:2] log_event;
  endproperty
  a_log_out: assert property (p_log_out) else $error("entry not logged");
  property p_refuse;
    cmd_w && reg_wdata[CMD_TO_SAFE] && |ctl_sh[3:1] && !standby_takeover
      && !dual_exec_compare_en |=> !dual_exec_compare_en [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("debug exit taken");
  property p_lock;
    cmd_w && reg_wdata[CMD_TO_MAINT] && ctl_sh[CTRL_AUTH_EN]
      && !maintenance_authorization_input && !auth_input_error
      && dual_exec_compare_en |=> dual_exec_compare_en [*3];
  endproperty
  a_lock: assert property (p_lock) else $error("locked entry taken");
  property p_mwords;
    reg_rd && !dual_exec_compare_en |=>
      ($past(reg_addr) != REG_COPRO_WORD || reg_rdata == WORD_COPRO_MAINT)
      && ($past(reg_addr) != REG_CTRL_WORD || reg_rdata == WORD_CTRL_MAINT);
  endproperty
  a_mwords: assert property (p_mwords) else $error("maint word bad");
  property p_swords;
    reg_rd && (reg_addr == REG_COPRO_WORD || reg_addr == REG_CTRL_WORD)
      && dual_exec_compare_en && safety_mode_led |=> reg_rdata == WORD_SAFE;
  endproperty
  a_swords: assert property (p_swords) else $error("safe word bad");
  property p_takeover;
    standby_takeover && !dual_exec_compare_en |-> ##[1:3] dual_exec_compare_en;
  endproperty
  a_takeover: assert property (p_takeover) else $error("no takeover");
  c_maint: cover property ($fell(dual_exec_compare_en));
  c_log: cover property (log_event);
  c_irq: cover property (irq);
endmodule
bind smm_manager smm_manager_monitor u_mon (.core_clk(core_clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .maintenance_authorization_input(maintenance_authorization_input),
  .auth_input_error(auth_input_error), .standby_takeover(standby_takeover),
  .safety_mode_led(safety_mode_led),
  .copro_safety_mode_led(copro_safety_mode_led),
  .dual_exec_compare_en(dual_exec_compare_en),
  .forcing_active(forcing_active), .log_event(log_event), .irq(irq));

// ---- smm_pkg.sv ----
package smm_pkg;
  // ------------------------------------------------------------
  // register offsets (word index on the plain register port)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_MASK = 4'h4;
  localparam logic [3:0] REG_COPRO_WORD = 4'h5;
  localparam logic [3:0] REG_CTRL_WORD = 4'h6;
  localparam logic [3:0] REG_LOG_COUNT = 4'h7;
  // ------------------------------------------------------------
  // control register bits
  // ------------------------------------------------------------
  localparam int CTRL_AUTH_EN = 0;
  localparam int CTRL_DEBUG = 1;
  localparam int CTRL_BREAK = 2;
  localparam int CTRL_WATCH = 3;
  localparam int CTRL_FORCE = 4;
  localparam int CTRL_APP_VALID = 5;
  localparam int CTRL_TEST_DONE = 6;
  localparam int CTRL_EXT_BAD = 7;
  localparam int CTRL_W = 8;
  // ------------------------------------------------------------
  // command register bits, write one to issue
  // ------------------------------------------------------------
  localparam int CMD_TO_MAINT = 0;
  localparam int CMD_TO_SAFE = 1;
  localparam int CMD_DISCONNECT = 2;
  localparam int CMD_HOST_ALIVE = 3;
  // ------------------------------------------------------------
  // interrupt bits
  // ------------------------------------------------------------
  localparam int IRQ_SAFE_ENTER = 0;
  localparam int IRQ_SAFE_EXIT = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_TIMEOUT = 3;
  localparam int IRQ_W = 4;
  // ------------------------------------------------------------
  // mode status words and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] WORD_COPRO_MAINT = 16'hA501;
  localparam logic [15:0] WORD_CTRL_MAINT = 16'h501A;
  localparam logic [15:0] WORD_SAFE = 16'h5AFE;
  localparam logic [15:0] WORD_IDLE = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int LINK_LOSS_S = 50;
  localparam longint LINK_LOSS_CYC = longint'(LINK_LOSS_S) * CLK_HZ;
  localparam int FLASH_HZ = 2;
  localparam int FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
  // ------------------------------------------------------------
  // operating states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SELF_TEST = 2'b00,
    ST_NO_CONFIG = 2'b01,
    ST_SAFETY = 2'b10,
    ST_MAINT = 2'b11
  } smm_state_t;
endpackage
